// >>> design/fxc_pkg.sv
// Shared constants, widths and the operation set of the float transfer control block
package fxc_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned FXC_WORD_W = 24;
  localparam int unsigned FXC_ACC_W  = 48;
  localparam int unsigned FXC_EXP_W  = 8;
  localparam int unsigned FXC_MANT_W = FXC_ACC_W - FXC_EXP_W;
  localparam int unsigned FXC_ADDR_W = 18;
  localparam int unsigned FXC_RADR_W = 4;
  localparam int unsigned FXC_COND_W = 4;

  // ==========================================================================
  // Condition register bit positions
  localparam int unsigned FXC_C_OVF = 0;
  localparam int unsigned FXC_C_NEG = 1;
  localparam int unsigned FXC_C_ZER = 2;
  localparam int unsigned FXC_C_POS = 3;

  // Trap state position in the integer accumulator word
  localparam int unsigned FXC_TRAP_BIT = 6;

  // ==========================================================================
  // Special values
  localparam logic [FXC_ACC_W-1:0]  FXC_ZERO_VAL  = 48'h0000_0000_0001;
  localparam logic [FXC_MANT_W-1:0] FXC_OVF_MANT  = 40'hC0_0000_0000;
  localparam logic [FXC_EXP_W-1:0]  FXC_OVF_EXP   = 8'h80;
  localparam logic [FXC_COND_W-1:0] FXC_COND_RST  = 4'h0;
  localparam logic                  FXC_TRAP_RST  = 1'b1;

  // ==========================================================================
  // Register map, word offsets on the plain register port
  localparam logic [FXC_RADR_W-1:0] FXC_R_COND   = 4'h0;
  localparam logic [FXC_RADR_W-1:0] FXC_R_TRAP   = 4'h1;
  localparam logic [FXC_RADR_W-1:0] FXC_R_ACC_HI = 4'h2;
  localparam logic [FXC_RADR_W-1:0] FXC_R_ACC_LO = 4'h3;
  localparam logic [FXC_RADR_W-1:0] FXC_R_AUX_HI = 4'h4;
  localparam logic [FXC_RADR_W-1:0] FXC_R_AUX_LO = 4'h5;
  localparam logic [FXC_RADR_W-1:0] FXC_R_STATUS = 4'h6;

  // ==========================================================================
  // Operations issued by the instruction sequencer
  typedef enum logic [3:0] {
    FXC_OP_COMPARE_ZERO_ACCUMULATOR,
    FXC_OP_HOLD_OVERFLOW_TRAP,
    FXC_OP_RELEASE_OVERFLOW_TRAP,
    FXC_OP_INTERCHANGE_AUX_ACCUMULATOR,
    FXC_OP_COPY_AUX_TO_ACCUMULATOR,
    FXC_OP_LOAD_ACCUMULATOR_FROM_MEMORY,
    FXC_OP_LOAD_EXPONENT_IMMEDIATE,
    FXC_OP_LOAD_CONDITION_IMMEDIATE,
    FXC_OP_COPY_ACCUMULATOR_TO_AUX,
    FXC_OP_STORE_ACCUMULATOR_TO_MEMORY,
    FXC_OP_COPY_CONDITION_TO_INTEGER,
    FXC_OP_CLEAR_ACCUMULATOR_TO_ZERO,
    FXC_OP_COMPARE_EXPONENT_IMMEDIATE
  } fxc_op_e;

endpackage : fxc_pkg

// >>> design/fxc_stat_if.sv
// Carrier between the controller and its accumulator status evaluator
`timescale 1ns/1ps
`default_nettype none

interface fxc_stat_if;
  import fxc_pkg::*;

  logic [FXC_ACC_W-1:0]  value;
  logic [FXC_COND_W-1:0] cond;
  logic                  ovf_pattern;

  modport eval (input value, output cond, output ovf_pattern);
  modport user (output value, input cond, input ovf_pattern);
endinterface : fxc_stat_if

`default_nettype wire

// >>> design/fxc_status_eval.sv
// Sign, zero and overflow-pattern status of a floating accumulator value
`timescale 1ns/1ps
`default_nettype none

module fxc_status_eval
  import fxc_pkg::*;
(
  fxc_stat_if.eval st
);

  logic [FXC_MANT_W-1:0] mant;
  logic [FXC_EXP_W-1:0]  expo;

  assign mant = st.value[FXC_ACC_W-1:FXC_EXP_W];
  assign expo = st.value[FXC_EXP_W-1:0];

  // ==========================================================================
  // Status flags; overflow is never produced here, the caller adds it
  always_comb begin
    st.cond            = '0;
    st.cond[FXC_C_NEG] = mant[FXC_MANT_W-1];
    st.cond[FXC_C_ZER] = (mant == '0);
    st.cond[FXC_C_POS] = !mant[FXC_MANT_W-1] && (mant != '0);
  end

  assign st.ovf_pattern = (mant == FXC_OVF_MANT) && (expo == FXC_OVF_EXP);

endmodule : fxc_status_eval

`default_nettype wire

// >>> design/fxc_transfer_ctrl.sv
// Transfer, compare and trap-control datapath of the floating coprocessor
//
// Notes on behaviour
// - Compare-zero loads condition with sign and zero status of the accumulator.
// - Compare-zero flags overflow when accumulator holds the 110..0/10..0 pattern.
// - On that pattern compare-zero forces accumulator bit 0 to one.
// - Hold-overflow-trap disarms the overflow/underflow trap.
// - A disarmed trap stays disarmed until release-overflow-trap runs or software writes 0 to the trap register.
// - Release-overflow-trap arms the overflow/underflow trap.
// - Armed trap, external interrupts not held, overflow set: raise trap request.
// - Interchange swaps accumulator and auxiliary register in one operation.
// - After interchange, condition reflects the new accumulator.
// - Copy-aux-to-accumulator replaces the accumulator with the auxiliary value.
// - Memory load: effective address word is high part, next word low part.
// - Load-exponent puts the signed 8-bit immediate in the exponent only.
// - After load-exponent, condition reflects the mantissa of the new accumulator.
// - Load-condition writes the 4-bit immediate: overflow, negative, zero, positive.
// - Copy-accumulator-to-aux leaves the accumulator unchanged.
// - Store: high part to effective address, low part to the next address.
// - Condition-to-integer puts flags in bits 0-3, trap disabled state in bit 6.
// - Condition-to-integer clears every other integer accumulator bit.
// - Clear-to-zero loads the canonical zero with lowest bit one.
// - Clear-to-zero leaves the condition register untouched.
// - Exponent compare: greater gives positive, smaller gives negative.
`timescale 1ns/1ps
`default_nettype none

module fxc_transfer_ctrl
  import fxc_pkg::*;
#(
  parameter int unsigned ADDR_W = FXC_ADDR_W
) (
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire logic                  op_valid,
  input  wire fxc_op_e               op_code,
  input  wire logic [FXC_EXP_W-1:0]  op_imm,
  input  wire logic [ADDR_W-1:0]     op_ea,
  output logic                       op_ready,
  output logic                       op_done,
  output logic                       mem_req,
  output logic                       mem_we,
  output logic [ADDR_W-1:0]          mem_addr,
  output logic [FXC_WORD_W-1:0]      mem_wdata,
  input  wire logic                  mem_ack,
  input  wire logic [FXC_WORD_W-1:0] mem_rdata,
  output logic [FXC_WORD_W-1:0]      int_acc_data,
  output logic                       int_acc_we,
  input  wire logic                  hold_external_interrupts,
  output logic                       trap_req,
  input  wire logic [FXC_RADR_W-1:0] reg_addr,
  input  wire logic [FXC_WORD_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [FXC_WORD_W-1:0]      reg_rdata
);

  typedef enum logic [2:0] {
    FXC_S_IDLE,
    FXC_S_LD_HI,
    FXC_S_LD_LO,
    FXC_S_ST_HI,
    FXC_S_ST_LO
  } fxc_state_e;

  fxc_state_e              state_reg;
  fxc_state_e              state_next;
  logic [FXC_ACC_W-1:0]    acc_reg;
  logic [FXC_ACC_W-1:0]    acc_next;
  logic [FXC_ACC_W-1:0]    aux_reg;
  logic [FXC_ACC_W-1:0]    aux_next;
  logic [FXC_COND_W-1:0]   cond_reg;
  logic [FXC_COND_W-1:0]   cond_next;
  logic                    cond_load;
  logic                    trap_disarmed_reg;
  logic [FXC_WORD_W-1:0]   ld_hi_reg;
  logic                    op_go;
  logic                    ld_finish;
  logic                    st_finish;
  logic                    cow_gt;
  logic                    cow_lt;

  fxc_stat_if st_acc ();
  fxc_stat_if st_new ();

  fxc_status_eval u_eval_acc (
    .st (st_acc)
  );

  fxc_status_eval u_eval_new (
    .st (st_new)
  );

  // ==========================================================================
  // Helpers
  function automatic logic [FXC_WORD_W-1:0] fxc_int_word(
    input logic [FXC_COND_W-1:0] cond,
    input logic                  disarmed
  );
    logic [FXC_WORD_W-1:0] w;
    w               = '0;
    w[FXC_COND_W-1:0] = cond;
    w[FXC_TRAP_BIT] = disarmed;
    return w;
  endfunction : fxc_int_word

  function automatic logic fxc_is_op(
    input logic    go,
    input fxc_op_e code,
    input fxc_op_e want
  );
    return go && (code == want);
  endfunction : fxc_is_op

  assign op_ready  = (state_reg == FXC_S_IDLE);
  assign op_go     = op_valid && op_ready;
  assign ld_finish = (state_reg == FXC_S_LD_LO) && mem_ack;
  assign st_finish = (state_reg == FXC_S_ST_LO) && mem_ack;
  assign cow_gt    = $signed(acc_reg[FXC_EXP_W-1:0]) > $signed(op_imm);
  assign cow_lt    = $signed(acc_reg[FXC_EXP_W-1:0]) < $signed(op_imm);

  assign st_acc.value = acc_reg;
  assign st_new.value = acc_next;

  // ==========================================================================
  // Datapath next values
  always_comb begin
    acc_next  = acc_reg;
    aux_next  = aux_reg;
    cond_next = cond_reg;
    cond_load = 1'b0;
    if (ld_finish) begin
      acc_next  = {ld_hi_reg, mem_rdata};
      cond_next = st_new.cond;
      cond_load = 1'b1;
    end else if (op_go) begin
      case (op_code)
        FXC_OP_COMPARE_ZERO_ACCUMULATOR: begin
          cond_next = st_acc.cond;
          if (st_acc.ovf_pattern) begin
            cond_next[FXC_C_OVF] = 1'b1;
            acc_next[0]          = 1'b1;
          end
          cond_load = 1'b1;
        end
        FXC_OP_INTERCHANGE_AUX_ACCUMULATOR: begin
          acc_next  = aux_reg;
          aux_next  = acc_reg;
          cond_next = st_new.cond;
          cond_load = 1'b1;
        end
        FXC_OP_COPY_AUX_TO_ACCUMULATOR: begin
          acc_next  = aux_reg;
          cond_next = st_new.cond;
          cond_load = 1'b1;
        end
        FXC_OP_LOAD_EXPONENT_IMMEDIATE: begin
          acc_next[FXC_EXP_W-1:0] = op_imm;
          cond_next = st_new.cond;
          cond_load = 1'b1;
        end
        FXC_OP_LOAD_CONDITION_IMMEDIATE: begin
          cond_next = op_imm[FXC_COND_W-1:0];
          cond_load = 1'b1;
        end
        FXC_OP_COPY_ACCUMULATOR_TO_AUX: begin
          aux_next = acc_reg;
        end
        FXC_OP_CLEAR_ACCUMULATOR_TO_ZERO: begin
          acc_next = FXC_ZERO_VAL;
        end
        FXC_OP_COMPARE_EXPONENT_IMMEDIATE: begin
          cond_next            = '0;
          cond_next[FXC_C_POS] = cow_gt;
          cond_next[FXC_C_NEG] = cow_lt;
          cond_next[FXC_C_ZER] = !cow_gt && !cow_lt;
          cond_load            = 1'b1;
        end
        default: begin
          cond_load = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Sequencer for the two-word memory transfers
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FXC_S_IDLE: begin
        if (fxc_is_op(op_go, op_code, FXC_OP_LOAD_ACCUMULATOR_FROM_MEMORY)) begin
          state_next = FXC_S_LD_HI;
        end else if (fxc_is_op(op_go, op_code, FXC_OP_STORE_ACCUMULATOR_TO_MEMORY)) begin
          state_next = FXC_S_ST_HI;
        end
      end
      FXC_S_LD_HI: begin
        if (mem_ack) begin
          state_next = FXC_S_LD_LO;
        end
      end
      FXC_S_ST_HI: begin
        if (mem_ack) begin
          state_next = FXC_S_ST_LO;
        end
      end
      FXC_S_LD_LO,
      FXC_S_ST_LO: begin
        if (mem_ack) begin
          state_next = FXC_S_IDLE;
        end
      end
      default: begin
        state_next = FXC_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= FXC_S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Memory port; address and data move to the second word on the first ack
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= '0;
      ld_hi_reg <= '0;
    end else if (state_reg == FXC_S_IDLE) begin
      if (fxc_is_op(op_go, op_code, FXC_OP_LOAD_ACCUMULATOR_FROM_MEMORY)) begin
        mem_req  <= 1'b1;
        mem_we   <= 1'b0;
        mem_addr <= op_ea;
      end else if (fxc_is_op(op_go, op_code, FXC_OP_STORE_ACCUMULATOR_TO_MEMORY)) begin
        mem_req   <= 1'b1;
        mem_we    <= 1'b1;
        mem_addr  <= op_ea;
        mem_wdata <= acc_reg[FXC_ACC_W-1:FXC_WORD_W];
      end
    end else if (mem_ack) begin
      if (state_reg == FXC_S_LD_HI || state_reg == FXC_S_ST_HI) begin
        mem_addr  <= mem_addr + ADDR_W'(1);
        mem_wdata <= acc_reg[FXC_WORD_W-1:0];
        ld_hi_reg <= mem_rdata;
      end else begin
        mem_req <= 1'b0;
        mem_we  <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Floating registers and condition; an operation wins over a software write
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acc_reg <= FXC_ZERO_VAL;
      aux_reg <= FXC_ZERO_VAL;
    end else begin
      acc_reg <= acc_next;
      aux_reg <= aux_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cond_reg <= FXC_COND_RST;
    end else if (cond_load) begin
      cond_reg <= cond_next;
    end else if (reg_wr && reg_addr == FXC_R_COND) begin
      cond_reg <= reg_wdata[FXC_COND_W-1:0];
    end
  end

  // Trap arm state; set means disarmed
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      trap_disarmed_reg <= FXC_TRAP_RST;
    end else if (fxc_is_op(op_go, op_code, FXC_OP_HOLD_OVERFLOW_TRAP)) begin
      trap_disarmed_reg <= 1'b1;
    end else if (fxc_is_op(op_go, op_code, FXC_OP_RELEASE_OVERFLOW_TRAP)) begin
      trap_disarmed_reg <= 1'b0;
    end else if (reg_wr && reg_addr == FXC_R_TRAP) begin
      trap_disarmed_reg <= reg_wdata[0];
    end
  end

  // Trap request on any operation that loads the overflow flag set, while the trap is armed and external interrupts are not held
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      trap_req <= 1'b0;
    end else begin
      trap_req <= cond_load && cond_next[FXC_C_OVF] && !trap_disarmed_reg
                  && !hold_external_interrupts;
    end
  end

  // Integer accumulator write and completion pulse
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      int_acc_data <= '0;
      int_acc_we   <= 1'b0;
      op_done      <= 1'b0;
    end else begin
      int_acc_we <= fxc_is_op(op_go, op_code, FXC_OP_COPY_CONDITION_TO_INTEGER);
      if (fxc_is_op(op_go, op_code, FXC_OP_COPY_CONDITION_TO_INTEGER)) begin
        int_acc_data <= fxc_int_word(cond_reg, trap_disarmed_reg);
      end
      op_done <= ld_finish || st_finish
                 || (op_go && op_code != FXC_OP_LOAD_ACCUMULATOR_FROM_MEMORY
                     && op_code != FXC_OP_STORE_ACCUMULATOR_TO_MEMORY);
    end
  end

  // ==========================================================================
  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        FXC_R_COND:   reg_rdata <= FXC_WORD_W'(cond_reg);
        FXC_R_TRAP:   reg_rdata <= FXC_WORD_W'(trap_disarmed_reg);
        FXC_R_ACC_HI: reg_rdata <= acc_reg[FXC_ACC_W-1:FXC_WORD_W];
        FXC_R_ACC_LO: reg_rdata <= acc_reg[FXC_WORD_W-1:0];
        FXC_R_AUX_HI: reg_rdata <= aux_reg[FXC_ACC_W-1:FXC_WORD_W];
        FXC_R_AUX_LO: reg_rdata <= aux_reg[FXC_WORD_W-1:0];
        FXC_R_STATUS: reg_rdata <= FXC_WORD_W'(!op_ready);
        default:      reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence st_first_word;
    mem_req && mem_we && mem_addr == $past(op_ea)
      && mem_wdata == $past(acc_reg[FXC_ACC_W-1:FXC_WORD_W]);
  endsequence

  sequence ld_first_word;
    mem_req && !mem_we && mem_addr == $past(op_ea);
  endsequence

  czx_overflow_a: assert property (
    fxc_is_op(op_go, op_code, FXC_OP_COMPARE_ZERO_ACCUMULATOR) && st_acc.ovf_pattern
    |=> cond_reg[FXC_C_OVF] && acc_reg[0])
    else $error("overflow pattern not flagged by compare zero");

  czx_sign_a: assert property (
    fxc_is_op(op_go, op_code, FXC_OP_COMPARE_ZERO_ACCUMULATOR) && acc_reg == FXC_ZERO_VAL
    |=> cond_reg == 4'h4)
    else $error("compare zero of zero did not give zero");

  trap_hold_a: assert property (
    fxc_is_op(op_go, op_code, FXC_OP_HOLD_OVERFLOW_TRAP) |=> trap_disarmed_reg)
    else $error("trap not disarmed by hold");

  trap_stays_a: assert property (
    trap_disarmed_reg && !fxc_is_op(op_go, op_code, FXC_OP_RELEASE_OVERFLOW_TRAP)
    && !(reg_wr && reg_addr == FXC_R_TRAP) |=> trap_disarmed_reg)
    else $error("trap rearmed without release");

  trap_release_a: assert property (
    fxc_is_op(op_go, op_code, FXC_OP_RELEASE_OVERFLOW_TRAP) |=> !trap_disarmed_reg)
    else $error("trap not armed by release");

  trap_request_a: assert property (
    fxc_is_op(op_go, op_code, FXC_OP_LOAD_CONDITION_IMMEDIATE) && op_imm[FXC_C_OVF]
    && !trap_disarmed_reg && !hold_external_interrupts |=> trap_req ##1 !trap_req)
    else $error("trap request missing or not one cycle");

  swap_regs_a: assert property (
    fxc_is_op(op_go, op_code, FXC_OP_INTERCHANGE_AUX_ACCUMULATOR)
    |=> acc_reg == $past(aux_reg) && aux_reg == $past(acc_reg) && cond_reg == st_acc.cond)
    else $error("interchange wrong");

  aux_copy_a: assert property (
    fxc_is_op(op_go, op_code, FXC_OP_COPY_ACCUMULATOR_TO_AUX)
    |=> aux_reg == $past(acc_reg) && $stable(acc_reg))
    else $error("copy to aux wrong");

  load_pair_a: assert property (
    fxc_is_op(op_go, op_code, FXC_OP_LOAD_ACCUMULATOR_FROM_MEMORY) |=> ld_first_word)
    else $error("load does not start at effective address");

  store_pair_a: assert property (
    fxc_is_op(op_go, op_code, FXC_OP_STORE_ACCUMULATOR_TO_MEMORY) |=> st_first_word)
    else $error("store does not start with high part");

  exp_load_a: assert property (
    fxc_is_op(op_go, op_code, FXC_OP_LOAD_EXPONENT_IMMEDIATE)
    |=> acc_reg[FXC_EXP_W-1:0] == $past(op_imm)
        && acc_reg[FXC_ACC_W-1:FXC_EXP_W] == $past(acc_reg[FXC_ACC_W-1:FXC_EXP_W]))
    else $error("exponent load touched other bits");

  cond_imm_a: assert property (
    fxc_is_op(op_go, op_code, FXC_OP_LOAD_CONDITION_IMMEDIATE)
    |=> cond_reg == $past(op_imm[FXC_COND_W-1:0]))
    else $error("condition immediate not loaded");

  int_word_a: assert property (
    int_acc_we |-> int_acc_data[FXC_WORD_W-1:FXC_TRAP_BIT+1] == '0
    && int_acc_data[FXC_TRAP_BIT-1:FXC_COND_W] == '0)
    else $error("integer word has stray bits");

  zero_load_a: assert property (
    fxc_is_op(op_go, op_code, FXC_OP_CLEAR_ACCUMULATOR_TO_ZERO)
    && !(reg_wr && reg_addr == FXC_R_COND)
    |=> acc_reg == FXC_ZERO_VAL && $stable(cond_reg))
    else $error("clear to zero wrong");

  exp_compare_a: assert property (
    fxc_is_op(op_go, op_code, FXC_OP_COMPARE_EXPONENT_IMMEDIATE) && cow_gt
    |=> cond_reg == 4'h8)
    else $error("exponent compare greater not positive");

endmodule : fxc_transfer_ctrl

`default_nettype wire

// >>> sim/fxc_mem_model.sv
// Memory port partner answering word requests with alternating delays
`timescale 1ns/1ps
`default_nettype none

module fxc_mem_model
  import fxc_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  mem_req,
  input  wire logic                  mem_we,
  input  wire logic [17:0]           mem_addr,
  input  wire logic [FXC_WORD_W-1:0] mem_wdata,
  output logic                       mem_ack,
  output logic [FXC_WORD_W-1:0]      mem_rdata
);
  logic [FXC_WORD_W-1:0] mem [16];
  logic [1:0]            cnt = 2'h0;
  logic [1:0]            dly = 2'h0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 24'h000000;
  // One word at mem_addr[3:0] per acknowledged request
  always @(posedge clk_sys) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (cnt == dly) begin
        mem_ack <= 1'b1;
        cnt <= 2'h0;
        dly <= dly ^ 2'h3;
        mem_rdata <= mem[mem_addr[3:0]];
        if (mem_we) mem[mem_addr[3:0]] <= mem_wdata;
      end else cnt <= cnt + 2'h1;
    end
  end
endmodule : fxc_mem_model

`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench of the float transfer control block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import fxc_pkg::*;
  logic clk_sys = 0, srst = 1, op_valid = 0, hx = 0, reg_wr = 0, reg_rd = 0;
  logic mem_ack, mem_req, mem_we, op_ready, op_done, int_acc_we, trap_req, tr;
  fxc_op_e op_code = FXC_OP_HOLD_OVERFLOW_TRAP;
  logic [7:0] op_imm = 8'h00;
  logic [17:0] op_ea = 18'h00000, mem_addr;
  logic [3:0] reg_addr = 4'h0;
  logic [23:0] reg_wdata = 24'h000000, mem_wdata, mem_rdata, int_acc_data, reg_rdata, ia;
  logic [47:0] d;
  logic [31:0] s = 44796;
  int n_mismatch = 0, tests_run = 0, i;
  logic [7:0] e, m;
  always #2.5 clk_sys = ~clk_sys;
  fxc_transfer_ctrl uut (.clk_sys(clk_sys), .srst(srst), .op_valid(op_valid),
    .op_code(op_code), .op_imm(op_imm), .op_ea(op_ea), .op_ready(op_ready),
    .op_done(op_done), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .int_acc_data(int_acc_data), .int_acc_we(int_acc_we),
    .hold_external_interrupts(hx), .trap_req(trap_req), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  fxc_mem_model mem (.clk_sys(clk_sys), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  function automatic logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  function automatic logic [3:0] st(logic [47:0] v);
    return v[47] ? 4'h2 : ((v[47:8] == 40'h0) ? 4'h4 : 4'h8);
  endfunction : st
  task automatic chk(string n, logic [47:0] seen, logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic op(fxc_op_e c, logic [7:0] imm, logic [17:0] ea);
    int k;
    logic done;
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_code <= c;
    op_imm <= imm;
    op_ea <= ea;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    tr = 1'b0;
    k = 0;
    // One-cycle outputs stand right after the take edge, so look there first
    do begin
      #1;
      k++;
      tr = tr | (trap_req === 1'b1);
      done = (op_done === 1'b1);
      if (!done) @(posedge clk_sys);
    end while (!done && k < 40);
    ia = int_acc_data;
    if (k >= 40) n_mismatch++;
  endtask : op
  task automatic rchk(string n, logic [3:0] a, logic [23:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(n, reg_rdata, exp);
  endtask : rchk
  task automatic end_sim();
    if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    rchk("acc_lo", FXC_R_ACC_LO, 24'h000001);
    rchk("trap", FXC_R_TRAP, 24'h000001);
    rchk("unmapped", 4'hF, 24'h000000);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= FXC_R_COND;
    reg_wdata <= 24'h000005;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    rchk("cond_wr", FXC_R_COND, 24'h000005);
    op(FXC_OP_LOAD_CONDITION_IMMEDIATE, 8'h01, 18'h0);
    chk("trap_disarmed", tr, 1'b0);
    op(FXC_OP_COPY_CONDITION_TO_INTEGER, 8'h00, 18'h0);
    chk("int_dis", ia, 24'h000041);
    op(FXC_OP_RELEASE_OVERFLOW_TRAP, 8'h00, 18'h0);
    op(FXC_OP_LOAD_CONDITION_IMMEDIATE, 8'hF9, 18'h0);
    chk("trap_armed", tr, 1'b1);
    op(FXC_OP_COPY_CONDITION_TO_INTEGER, 8'h00, 18'h0);
    chk("int_en", ia, 24'h000009);
    hx <= 1'b1;
    op(FXC_OP_LOAD_CONDITION_IMMEDIATE, 8'h01, 18'h0);
    chk("trap_held", tr, 1'b0);
    hx <= 1'b0;
    op(FXC_OP_HOLD_OVERFLOW_TRAP, 8'h00, 18'h0);
    op(FXC_OP_LOAD_CONDITION_IMMEDIATE, 8'h03, 18'h0);
    chk("trap_stays", tr, 1'b0);
    for (i = 0; i < 8; i++) begin
      e = 8'(xs());
      m = (i == 0) ? e : 8'(xs());
      op(FXC_OP_LOAD_CONDITION_IMMEDIATE, m, 18'h0);
      rchk("cond_imm", FXC_R_COND, {20'h0, m[3:0]});
      op(FXC_OP_LOAD_EXPONENT_IMMEDIATE, e, 18'h0);
      rchk("exp_cond", FXC_R_COND, 24'h000004);
      rchk("exp_only", FXC_R_ACC_LO, {16'h0, e});
      op(FXC_OP_COMPARE_EXPONENT_IMMEDIATE, m, 18'h0);
      rchk("exp_cmp", FXC_R_COND, ($signed(e) > $signed(m)) ? 24'h8 :
        ($signed(e) < $signed(m)) ? 24'h2 : 24'h4);
    end
    d = 48'({xs(), xs()});
    mem.mem[2] = d[47:24];
    mem.mem[3] = d[23:0];
    op(FXC_OP_LOAD_ACCUMULATOR_FROM_MEMORY, 8'h00, 18'h2);
    rchk("ld_hi", FXC_R_ACC_HI, d[47:24]);
    rchk("ld_lo", FXC_R_ACC_LO, d[23:0]);
    op(FXC_OP_COPY_ACCUMULATOR_TO_AUX, 8'h00, 18'h0);
    rchk("aux_hi", FXC_R_AUX_HI, d[47:24]);
    rchk("acc_kept", FXC_R_ACC_LO, d[23:0]);
    op(FXC_OP_CLEAR_ACCUMULATOR_TO_ZERO, 8'h00, 18'h0);
    rchk("zero_lo", FXC_R_ACC_LO, 24'h000001);
    rchk("zero_cond", FXC_R_COND, {20'h0, st(d)});
    op(FXC_OP_INTERCHANGE_AUX_ACCUMULATOR, 8'h00, 18'h0);
    rchk("xchg_acc", FXC_R_ACC_HI, d[47:24]);
    rchk("xchg_aux", FXC_R_AUX_LO, 24'h000001);
    rchk("xchg_cond", FXC_R_COND, {20'h0, st(d)});
    op(FXC_OP_STORE_ACCUMULATOR_TO_MEMORY, 8'h00, 18'h8);
    chk("st_hi", mem.mem[8], d[47:24]);
    chk("st_lo", mem.mem[9], d[23:0]);
    op(FXC_OP_COMPARE_ZERO_ACCUMULATOR, 8'h00, 18'h0);
    rchk("cz_cond", FXC_R_COND, {20'h0, st(d)});
    op(FXC_OP_COPY_AUX_TO_ACCUMULATOR, 8'h00, 18'h0);
    rchk("aux_acc", FXC_R_ACC_HI, 24'h000000);
    mem.mem[4] = 24'hC00000;
    mem.mem[5] = 24'h000080;
    op(FXC_OP_LOAD_ACCUMULATOR_FROM_MEMORY, 8'h00, 18'h4);
    op(FXC_OP_COMPARE_ZERO_ACCUMULATOR, 8'h00, 18'h0);
    rchk("cz_ovf", FXC_R_COND, 24'h000003);
    rchk("cz_lsb", FXC_R_ACC_LO, 24'h000081);
    end_sim();
  end
endmodule : testbench

`default_nettype wire
